// file: hdl/pmws_status.sv
// Warning status bank: latched flags, command reads, summary bits
//
// Overview of operation
// - Overcurrent against threshold latches bit 5 of current status register.
// - Current status register bits 7 to 6 always read zero.
// - Supply above overvoltage threshold latches bit 6 of input status.
// - Supply below undervoltage threshold latches bit 5 of input status.
// - Input power crossing overpower threshold latches bit 0 of input status.
// - Input status bit 7 and bits 4 to 1 always read zero.
// - Auxiliary above overvoltage threshold latches bit 6 of vendor status.
// - Auxiliary below undervoltage threshold latches bit 5 of vendor status.
// - Bits 4 to 0 of current and vendor, vendor bit 7 read zero.
// - Reset clears all three status registers to zero.
// - Status word bits 14, 13, 12 show any set bit per register.
// - Positive power limit trips higher, negative limit trips more negative.
`include "pmws_defs.svh"

module pmws_status (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Averaged measurements and thresholds
	input wire logic meas_valid,
	input wire pmws_pkg::pmws_meas_type meas,
	input wire pmws_pkg::pmws_limits_type limits,
	// Command port from the serial engine
	input wire pmws_pkg::pmws_cmd_type cmd,
	// Read answer
	output logic rd_valid_q,
	output logic [7:0] rd_data_q,
	output logic rd_unmapped_q,
	// Register contents and summary
	output logic [7:0] current_warning_status_q,
	output logic [7:0] input_warning_status_q,
	output logic [7:0] vendor_warning_status_q,
	output logic [15:12] summary_q
);

	////////////////////////////////////////////////////////////////////////
	// Comparators

	pmws_pkg::pmws_events_type events;

	pmws_compare u_compare (
		.clk(clk),
		.rst_n(rst_n),
		.meas_valid(meas_valid),
		.meas(meas),
		.limits(limits),
		.events_q(events)
	);

	////////////////////////////////////////////////////////////////////////
	// Command decode

	logic hit_current;
	logic hit_input;
	logic hit_vendor;
	logic hit_clear;
	logic clear;

	assign hit_current = cmd.code == `PMWS_CMD_CURRENT;
	assign hit_input = cmd.code == `PMWS_CMD_INPUT;
	assign hit_vendor = cmd.code == `PMWS_CMD_VENDOR;
	assign hit_clear = cmd.code == `PMWS_CMD_CLEAR;
	assign clear = cmd.valid && hit_clear;

	////////////////////////////////////////////////////////////////////////
	// Latched flags

	logic overcurrent_flag_q;
	logic supply_overvoltage_flag_q;
	logic supply_undervoltage_flag_q;
	logic overpower_flag_q;
	logic aux_overvoltage_flag_q;
	logic aux_undervoltage_flag_q;
	logic overcurrent_flag_d;
	logic supply_overvoltage_flag_d;
	logic supply_undervoltage_flag_d;
	logic overpower_flag_d;
	logic aux_overvoltage_flag_d;
	logic aux_undervoltage_flag_d;

	assign overcurrent_flag_d = (overcurrent_flag_q && !clear) || events.overcurrent;
	assign supply_overvoltage_flag_d = (supply_overvoltage_flag_q && !clear) ||
		events.supply_overvoltage;
	assign supply_undervoltage_flag_d = (supply_undervoltage_flag_q && !clear) ||
		events.supply_undervoltage;
	assign overpower_flag_d = (overpower_flag_q && !clear) || events.overpower;
	assign aux_overvoltage_flag_d = (aux_overvoltage_flag_q && !clear) ||
		events.aux_overvoltage;
	assign aux_undervoltage_flag_d = (aux_undervoltage_flag_q && !clear) ||
		events.aux_undervoltage;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			overcurrent_flag_q <= 1'b0;
			supply_overvoltage_flag_q <= 1'b0;
			supply_undervoltage_flag_q <= 1'b0;
			overpower_flag_q <= 1'b0;
			aux_overvoltage_flag_q <= 1'b0;
			aux_undervoltage_flag_q <= 1'b0;
		end else begin
			overcurrent_flag_q <= overcurrent_flag_d;
			supply_overvoltage_flag_q <= supply_overvoltage_flag_d;
			supply_undervoltage_flag_q <= supply_undervoltage_flag_d;
			overpower_flag_q <= overpower_flag_d;
			aux_overvoltage_flag_q <= aux_overvoltage_flag_d;
			aux_undervoltage_flag_q <= aux_undervoltage_flag_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register images

	logic [7:0] current_image_d;
	logic [7:0] input_image_d;
	logic [7:0] vendor_image_d;

	// overcurrent field; upper bits zero; low bits zero
	always_comb begin
		current_image_d = `PMWS_STATUS_RESET;
		current_image_d[`PMWS_BIT_OVERCURRENT] = overcurrent_flag_d;
	end

	always_comb begin
		input_image_d = `PMWS_STATUS_RESET;
		input_image_d[`PMWS_BIT_SUPPLY_OV] = supply_overvoltage_flag_d;
		input_image_d[`PMWS_BIT_SUPPLY_UV] = supply_undervoltage_flag_d;
		input_image_d[`PMWS_BIT_OVERPOWER] = overpower_flag_d;
	end

	// aux overvoltage; aux undervoltage; rest zero
	always_comb begin
		vendor_image_d = `PMWS_STATUS_RESET;
		vendor_image_d[`PMWS_BIT_AUX_OV] = aux_overvoltage_flag_d;
		vendor_image_d[`PMWS_BIT_AUX_UV] = aux_undervoltage_flag_d;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			current_warning_status_q <= `PMWS_STATUS_RESET;
			input_warning_status_q <= `PMWS_STATUS_RESET;
			vendor_warning_status_q <= `PMWS_STATUS_RESET;
		end else begin
			current_warning_status_q <= current_image_d;
			input_warning_status_q <= input_image_d;
			vendor_warning_status_q <= vendor_image_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status word summary

	logic [15:12] summary_d;

	always_comb begin
		summary_d = '0;
		summary_d[`PMWS_WORD_CURRENT_BIT] = |current_image_d;
		summary_d[`PMWS_WORD_INPUT_BIT] = |input_image_d;
		summary_d[`PMWS_WORD_VENDOR_BIT] = |vendor_image_d;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			summary_q <= '0;
		end else begin
			summary_q <= summary_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read answer

	logic [7:0] rd_data_d;
	logic rd_unmapped_d;

	assign rd_data_d = hit_current ? current_warning_status_q :
		hit_input ? input_warning_status_q :
		hit_vendor ? vendor_warning_status_q : `PMWS_STATUS_RESET;
	assign rd_unmapped_d = !(hit_current || hit_input || hit_vendor || hit_clear);

	// Every command is answered one cycle later
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_valid_q <= 1'b0;
			rd_data_q <= `PMWS_STATUS_RESET;
			rd_unmapped_q <= 1'b0;
		end else begin
			rd_valid_q <= cmd.valid;
			rd_data_q <= cmd.valid ? rd_data_d : `PMWS_STATUS_RESET;
			rd_unmapped_q <= cmd.valid && rd_unmapped_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	overcurrent_latch_a: assert property (
		events.overcurrent |=> current_warning_status_q[`PMWS_BIT_OVERCURRENT])
		else $error("overcurrent event not latched");

	current_reserved_a: assert property (
		current_warning_status_q[7:6] == 2'h0)
		else $error("current status upper bits not zero");

	meas_to_supply_ov_a: assert property (
		meas_valid && meas.supply_voltage_input > limits.supply_overvoltage_threshold
		|=> ##1 input_warning_status_q[`PMWS_BIT_SUPPLY_OV])
		else $error("supply overvoltage not reported two cycles after result");

	supply_uv_latch_a: assert property (
		events.supply_undervoltage |=> input_warning_status_q[`PMWS_BIT_SUPPLY_UV])
		else $error("supply undervoltage not latched");

	overpower_latch_a: assert property (
		events.overpower |=> input_warning_status_q[`PMWS_BIT_OVERPOWER])
		else $error("overpower event not latched");

	input_reserved_a: assert property (
		input_warning_status_q[7] == 1'b0 && input_warning_status_q[4:1] == 4'h0)
		else $error("input status reserved bits not zero");

	aux_ov_latch_a: assert property (
		events.aux_overvoltage |=> vendor_warning_status_q[`PMWS_BIT_AUX_OV])
		else $error("aux overvoltage not latched");

	aux_uv_latch_a: assert property (
		events.aux_undervoltage |=> vendor_warning_status_q[`PMWS_BIT_AUX_UV])
		else $error("aux undervoltage not latched");

	low_reserved_a: assert property (
		current_warning_status_q[4:0] == 5'h00 && vendor_warning_status_q[4:0] == 5'h00 &&
		vendor_warning_status_q[7] == 1'b0)
		else $error("current or vendor reserved bits not zero");

	reset_clear_a: assert property (@(posedge clk) disable iff (1'b0)
		!rst_n |=> current_warning_status_q == 8'h00 && input_warning_status_q == 8'h00 &&
		vendor_warning_status_q == 8'h00 && summary_q == 4'h0)
		else $error("status not zero after reset");

	summary_live_a: assert property (
		summary_q[`PMWS_WORD_CURRENT_BIT] == |current_warning_status_q &&
		summary_q[`PMWS_WORD_INPUT_BIT] == |input_warning_status_q &&
		summary_q[`PMWS_WORD_VENDOR_BIT] == |vendor_warning_status_q &&
		!summary_q[`PMWS_WORD_RESERVED_BIT])
		else $error("summary bits disagree with status registers");

	flag_hold_a: assert property (
		input_warning_status_q[`PMWS_BIT_SUPPLY_OV] && !clear
		|=> input_warning_status_q[`PMWS_BIT_SUPPLY_OV])
		else $error("latched flag dropped without clear");

	clear_only_a: assert property (
		clear && !events.overcurrent |=> !current_warning_status_q[`PMWS_BIT_OVERCURRENT])
		else $error("clear command did not clear overcurrent flag");

	read_answer_a: assert property (
		cmd.valid && cmd.code == `PMWS_CMD_INPUT
		|=> rd_valid_q && rd_data_q == $past(input_warning_status_q))
		else $error("input status read returned wrong data");

	overcurrent_seen_c: cover property (
		meas_valid ##1 events.overcurrent ##1 current_warning_status_q != 8'h00);

	clear_race_c: cover property (clear && events.overpower);

	vendor_read_c: cover property (
		cmd.valid && cmd.code == `PMWS_CMD_VENDOR ##1 rd_data_q != 8'h00);

	unmapped_c: cover property (rd_unmapped_q);

endmodule // pmws_status

// file: common/pmws_defs.svh
// Command codes, field positions and reset values of the warning status bank
`ifndef PMWS_DEFS_SVH
`define PMWS_DEFS_SVH

// Command codes of the three status registers
`define PMWS_CMD_CURRENT 8'h7B
`define PMWS_CMD_INPUT 8'h7C
`define PMWS_CMD_VENDOR 8'h80
// Send-byte command that clears all latched warnings
`define PMWS_CMD_CLEAR 8'h03

// Reset value of every status register and of unmapped reads
`define PMWS_STATUS_RESET 8'h00

// Current status register fields
`define PMWS_BIT_OVERCURRENT 5
// Input status register fields
`define PMWS_BIT_SUPPLY_OV 6
`define PMWS_BIT_SUPPLY_UV 5
`define PMWS_BIT_OVERPOWER 0
// Vendor status register fields
`define PMWS_BIT_AUX_OV 6
`define PMWS_BIT_AUX_UV 5

// Summary positions within the top-level status word
`define PMWS_WORD_CURRENT_BIT 14
`define PMWS_WORD_INPUT_BIT 13
`define PMWS_WORD_VENDOR_BIT 12
`define PMWS_WORD_RESERVED_BIT 15

`endif

// file: common/pmws_pkg.sv
// Types shared by the warning status bank
package pmws_pkg;

	// Averaged measurement results
	typedef struct packed {
		logic [11:0] supply_voltage_input;
		logic [11:0] auxiliary_voltage_input;
		logic [15:0] load_current;
		logic [15:0] input_power;
	} pmws_meas_type;

	// Programmed warning thresholds
	typedef struct packed {
		logic [15:0] overcurrent_threshold;
		logic [11:0] supply_overvoltage_threshold;
		logic [11:0] supply_undervoltage_threshold;
		logic [15:0] overpower_threshold;
		logic [11:0] aux_overvoltage_threshold;
		logic [11:0] aux_undervoltage_threshold;
	} pmws_limits_type;

	// One-cycle limit crossing events
	typedef struct packed {
		logic overcurrent;
		logic supply_overvoltage;
		logic supply_undervoltage;
		logic overpower;
		logic aux_overvoltage;
		logic aux_undervoltage;
	} pmws_events_type;

	// Command from the serial protocol engine
	typedef struct packed {
		logic valid;
		logic [7:0] code;
	} pmws_cmd_type;

endpackage

// file: hdl/pmws_compare.sv
// Limit comparators, evaluated once per averaged measurement
module pmws_compare (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Measurement and thresholds
	input wire logic meas_valid,
	input wire pmws_pkg::pmws_meas_type meas,
	input wire pmws_pkg::pmws_limits_type limits,
	// Crossing events
	output pmws_pkg::pmws_events_type events_q
);

	////////////////////////////////////////////////////////////////////////
	// Compare functions

	function automatic logic above_u12(input logic [11:0] value, input logic [11:0] limit);
		above_u12 = value > limit;
	endfunction

	function automatic logic below_u12(input logic [11:0] value, input logic [11:0] limit);
		below_u12 = value < limit;
	endfunction

	// Sign of the limit picks the direction of the trip
	function automatic logic power_trip(input logic [15:0] value, input logic [15:0] limit);
		if (limit[15]) begin
			power_trip = $signed(value) < $signed(limit);
		end else begin
			power_trip = $signed(value) > $signed(limit);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Combinational trips

	pmws_pkg::pmws_events_type trip_d;

	assign trip_d.overcurrent = $signed(meas.load_current) > $signed(limits.overcurrent_threshold);
	assign trip_d.supply_overvoltage = above_u12(meas.supply_voltage_input,
		limits.supply_overvoltage_threshold);
	assign trip_d.supply_undervoltage = below_u12(meas.supply_voltage_input,
		limits.supply_undervoltage_threshold);
	assign trip_d.overpower = power_trip(meas.input_power, limits.overpower_threshold);
	assign trip_d.aux_overvoltage = above_u12(meas.auxiliary_voltage_input,
		limits.aux_overvoltage_threshold);
	assign trip_d.aux_undervoltage = below_u12(meas.auxiliary_voltage_input,
		limits.aux_undervoltage_threshold);

	////////////////////////////////////////////////////////////////////////
	// Event register

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			events_q <= '0;
		end else begin
			events_q <= meas_valid ? trip_d : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	power_sign_a: assert property (
		meas_valid && limits.overpower_threshold[15] &&
		$signed(meas.input_power) < $signed(limits.overpower_threshold) |=> events_q.overpower)
		else $error("negative power limit did not trip on a more negative reading");

	event_source_a: assert property (
		!meas_valid |=> events_q == '0)
		else $error("event raised without a new measurement");

endmodule // pmws_compare

// file: test/pmws_host_model.sv
// Host controller model that issues status reads and the clear command
module pmws_host_model (
	// Clock
	input wire logic clk,
	// Command to the bank
	output pmws_pkg::pmws_cmd_type cmd,
	// Answer from the bank
	input wire logic rd_valid_q,
	input wire logic [7:0] rd_data_q,
	input wire logic rd_unmapped_q
);
	timeunit 1ns;
	timeprecision 1ps;

	initial cmd = '{1'b0, 8'hA5};

	////////////////////////////////////////////////////////////////////////////////
	// clear and reads, one command at a time
	task automatic xfer(input logic [7:0] code, output logic [7:0] data, output logic unm);
		data = 8'hXX;
		unm = 1'bx;
		@(posedge clk);
		cmd <= '{1'b1, code};
		@(posedge clk);
		// Idle code lines change so a stale code never looks valid
		cmd <= '{1'b0, ~code};
		// Answer stands only in the cycle after the taking edge
		#1;
		if (rd_valid_q === 1'b1) begin
			data = rd_data_q;
			unm = rd_unmapped_q;
		end
	endtask
endmodule // pmws_host_model

// file: test/testbench.sv
// Self-checking bench for the warning status bank
`include "pmws_defs.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic meas_valid = 1'b0;
	pmws_pkg::pmws_meas_type meas = '0;
	pmws_pkg::pmws_limits_type limits = '0;
	pmws_pkg::pmws_cmd_type cmd;
	logic rd_valid_q;
	logic rd_unmapped_q;
	logic [7:0] rd_data_q;
	logic [7:0] cur_q;
	logic [7:0] in_q;
	logic [7:0] ven_q;
	logic [15:12] summary_q;
	int num_errors = 0;
	int n_tests = 0;

	always #4 clk = ~clk;

	pmws_status DUT (
		.clk(clk),
		.rst_n(rst_n),
		.meas_valid(meas_valid),
		.meas(meas),
		.limits(limits),
		.cmd(cmd),
		.rd_valid_q(rd_valid_q),
		.rd_data_q(rd_data_q),
		.rd_unmapped_q(rd_unmapped_q),
		.current_warning_status_q(cur_q),
		.input_warning_status_q(in_q),
		.vendor_warning_status_q(ven_q),
		.summary_q(summary_q)
	);

	pmws_host_model host (
		.clk(clk),
		.cmd(cmd),
		.rd_valid_q(rd_valid_q),
		.rd_data_q(rd_data_q),
		.rd_unmapped_q(rd_unmapped_q)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		$display("errors %0d, checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Images plus summary bits, summary derived from the expected images
	task automatic chk_img(input logic [23:0] exp);
		chk({cur_q, in_q, ven_q}, exp);
		chk({20'h0, summary_q}, {20'h0, 1'b0, |exp[23:16], |exp[15:8], |exp[7:0]});
	endtask

	task automatic rd(input logic [7:0] code, input logic [7:0] exp, input logic unm);
		logic [7:0] d;
		logic u;
		host.xfer(code, d, u);
		chk({15'h0, u, d}, {15'h0, unm, exp});
	endtask

	// One averaged result, then wait the two edges until the flags show
	task automatic meas_step(input pmws_pkg::pmws_meas_type m, input logic [15:0] op);
		@(posedge clk);
		meas_valid <= 1'b1;
		meas <= m;
		limits <= '{16'h00FF, 12'h7FF, 12'h101, op, 12'h8FF, 12'h100};
		@(posedge clk);
		meas_valid <= 1'b0;
		meas <= ~m;
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic trip(input logic [11:0] s, a, input logic [15:0] c, p, op,
			input logic [23:0] exp);
		meas_step('{s, a, c, p}, op);
		chk_img(exp);
		meas_step('{12'h400, 12'h400, 16'h0000, 16'h0000}, op);
		chk_img(exp);
		rd(`PMWS_CMD_CURRENT, exp[23:16], 1'b0);
		rd(`PMWS_CMD_INPUT, exp[15:8], 1'b0);
		rd(`PMWS_CMD_VENDOR, exp[7:0], 1'b0);
		rd(`PMWS_CMD_CLEAR, 8'h00, 1'b0);
		chk_img(24'h0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		chk_img(24'h0);
		rd(`PMWS_CMD_CURRENT, 8'h00, 1'b0);
		rd(`PMWS_CMD_INPUT, 8'h00, 1'b0);
		rd(`PMWS_CMD_VENDOR, 8'h00, 1'b0);
		rd(8'h79, 8'h00, 1'b1);
		trip(12'h400, 12'h400, 16'h0100, 16'h0000, 16'h1000, 24'h200000);
		trip(12'h400, 12'h400, 16'h00FF, 16'h0000, 16'h1000, 24'h000000);
		trip(12'h800, 12'h400, 16'h0000, 16'h0000, 16'h1000, 24'h004000);
		trip(12'h7FF, 12'h400, 16'h0000, 16'h0000, 16'h1000, 24'h000000);
		trip(12'h100, 12'h400, 16'h0000, 16'h0000, 16'h1000, 24'h002000);
		trip(12'h400, 12'h400, 16'h0000, 16'h1001, 16'h1000, 24'h000100);
		trip(12'h400, 12'h400, 16'h0000, 16'hEFFF, 16'hF000, 24'h000100);
		trip(12'h400, 12'h400, 16'h0000, 16'h0100, 16'hF000, 24'h000000);
		trip(12'h400, 12'h900, 16'h0000, 16'h0000, 16'h1000, 24'h000040);
		trip(12'h400, 12'h0FF, 16'h0000, 16'h0000, 16'h1000, 24'h000020);
		trip(12'h800, 12'h900, 16'h0100, 16'h1001, 16'h1000, 24'h204140);
		// Crossing values without the valid strobe must be ignored
		@(posedge clk);
		meas <= '{12'h800, 12'h900, 16'h0100, 16'h1001};
		repeat (3) @(posedge clk);
		#1;
		chk_img(24'h0);
		meas_step('{12'h800, 12'h900, 16'h0100, 16'h1001}, 16'h1000);
		chk_img(24'h204140);
		// Clear meets a fresh overpower event in one cycle: the set must win
		@(posedge clk);
		meas_valid <= 1'b1;
		meas <= '{12'h400, 12'h400, 16'h0000, 16'h1001};
		fork
			rd(`PMWS_CMD_CLEAR, 8'h00, 1'b0);
			begin
				@(posedge clk);
				meas_valid <= 1'b0;
			end
		join
		chk_img(24'h000100);
		@(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk_img(24'h0);
		wrap_up;
	end

	initial begin
		repeat (5000) @(posedge clk);
		num_errors++;
		wrap_up;
	end
endmodule // testbench
